// File: design/fri_pkg.sv
// Constants, register map and encodings of the flash read interface
package fri_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] REG_READ_CTRL = 8'h00;
  localparam logic [7:0] REG_SM_WEN    = 8'h04;
  localparam logic [7:0] REG_DBANK_CFG = 8'h08;
  localparam logic [7:0] REG_BANK_PWR  = 8'h0C;
  localparam logic [7:0] REG_PUMP_PWR1 = 8'h10;
  localparam logic [7:0] REG_PUMP_PWR2 = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_CFG_LO    = 8'h1C;
  localparam logic [7:0] REG_CFG_HI    = 8'h20;

  // Field positions
  localparam int PIPE_BIT      = 0;
  localparam int AWS_LSB       = 8;
  localparam int DWS_LSB       = 16;
  localparam int SMWEN_BIT     = 0;
  localparam int IDLE_LSB      = 16;
  localparam int STAT_PUMP_LSB = 16;
  localparam int STAT_CFG_BIT  = 20;
  localparam int STAT_DED_BIT  = 21;

  // Clock and zero-wait threshold
  localparam int CLK_MHZ       = 50;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ZERO_WAIT_MHZ = 45;

  // Values after reset: safe wait states above the zero-wait threshold
  localparam logic       RST_PIPE = 1'b0;
  localparam logic [1:0] RST_AWS  = (CLK_MHZ > ZERO_WAIT_MHZ) ? 2'h1 : 2'h0;
  localparam logic [3:0] RST_DWS  = (CLK_MHZ > ZERO_WAIT_MHZ) ? 4'h3 : 4'h0;
  localparam logic [4:0] RST_CNT  = {3'h0, RST_AWS} + {1'h0, RST_DWS};

  // Power mode encoding
  localparam logic [1:0] PWR_ACTIVE  = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_SLEEP   = 2'h2;

  // Wake-up time of a bank or the pump
  localparam int         WAKE_TIME_NS = 100;
  localparam logic [3:0] WAKE_CYCLES  =
    4'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Address map
  localparam int          NUM_BANKS     = 8;
  localparam int          BANK_LSB      = 21;
  localparam logic [2:0]  DATA_BANK     = 3'h7;
  localparam logic [3:0]  OTP_REGION    = 4'hF;
  localparam logic [31:0] OTP_CFG_ADDR  = 32'hF008_0140;
  localparam logic [31:0] SEC_TEST_ADDR = 32'hF008_03F0;
  localparam logic [31:0] DED_TEST_ADDR = 32'hF008_03F8;

endpackage : fri_pkg

// File: design/fri_secded.sv
// Single-error-correct, double-error-detect decoder for one 64-bit word
`timescale 1ns/100ps
`default_nettype none
module fri_secded
  import fri_pkg::*;
(
  // Stored word
  input  wire logic [63:0] data,
  input  wire logic [7:0]  check,
  // Result
  output logic      [63:0] fixed,
  output logic             sec,
  output logic             ded
);

  logic [71:0] cw;
  logic [6:0]  syn;
  logic        par;

  // Hamming positions 1..71, check bits at powers of two, bit 7 overall parity
  always_comb begin
    int j;
    int k;
    j     = 0;
    k     = 0;
    cw    = '0;
    syn   = '0;
    fixed = '0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) == 0) begin
        cw[p] = check[k];
        k++;
      end else begin
        cw[p] = data[j];
        j++;
      end
    end
    for (int p = 1; p < 72; p++) begin
      if (cw[p]) syn = syn ^ 7'(p);
    end
    par = (^cw) ^ check[7];
    sec = par;
    ded = !par && (syn != 7'h00);
    // Odd parity means one flipped bit; syndrome points at it
    if (par) cw[syn] = !cw[syn];
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        fixed[j] = cw[p];
        j++;
      end
    end
  end

endmodule : fri_secded
`default_nettype wire

// File: design/fri_pwr_unit.sv
// Power mode sequencer of one flash bank or of the charge pump
`timescale 1ns/100ps
`default_nettype none
module fri_pwr_unit
  import fri_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Activity and settings
  input  wire logic        touch,
  input  wire logic        wake,
  input  wire logic [1:0]  fallback,
  input  wire logic [15:0] idle_limit,
  // Current mode
  output logic      [1:0]  mode
);

  typedef struct packed {
    logic [1:0]  mode;
    logic [15:0] icnt;
    logic [3:0]  wcnt;
  } fri_pwr_type;

  fri_pwr_type s;
  fri_pwr_type next_s;

  // Idle timer drops to fallback; wake timer restores active
  always_comb begin
    next_s = s;
    if (s.mode != PWR_ACTIVE) begin
      if (wake) begin
        next_s.wcnt = s.wcnt + 4'h1;
        if (s.wcnt == WAKE_CYCLES - 4'h1) begin
          next_s.mode = PWR_ACTIVE;
          next_s.wcnt = '0;
          next_s.icnt = '0;
        end
      end else begin
        next_s.wcnt = '0;
      end
    end else if (touch || wake) begin
      next_s.icnt = '0;
    end else if (idle_limit != 16'h0000 && fallback != PWR_ACTIVE) begin
      // Zero limit keeps the unit active for good
      next_s.icnt = s.icnt + 16'h0001;
      if (s.icnt == idle_limit - 16'h0001) begin
        next_s.mode = fallback;
        next_s.icnt = '0;
      end
    end
  end

  // All units start active
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s      <= '0;
      s.mode <= PWR_ACTIVE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign mode = s.mode;

endmodule : fri_pwr_unit
`default_nettype wire

// File: design/fri_flash_read_if.sv
// Flash read interface: wait states, line buffer, power sequencing, reset vector
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - With zero programmed wait states a read completes without wait cycles.
// - Above 45 MHz each buffer miss inserts programmed address and data wait states.
// - Pipeline mode fetches 128-bit lines; buffer hits answer with no wait.
// - Buffered or fetched data serves 32-bit or 64-bit reads.
// - One read-control register holds wait counts and the pipeline enable.
// - Data bank 7 uses its own access configuration register.
// - Data-bank configuration writes are ignored unless the write enable is set.
// - Active, standby (banks only) and sleep modes gate amplifiers, reference, pump.
// - After reset all banks and the pump are active.
// - Idle timers drop each bank and the pump to its fallback mode.
// - A buffer miss to a non-active bank wakes that bank and the pump first.
// - Program and erase are granted only on active banks.
// - Bank power by bank register; pump power by two pump registers.
// - At reset the 64-bit vector at the OTP address is read and SECDED checked.
// - Double error in the vector raises group3 and pulls the fault pin low.
// - Single error in the vector is corrected silently.
// - Reads of the two test words report single and double errors.
module fri_flash_read_if
  import fri_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Master read port
  input  wire logic                       rd_req,
  input  wire logic [31:0]                rd_addr,
  input  wire logic                       rd_wide,
  output logic                            rd_ready,
  output logic                            rd_valid,
  output logic      [63:0]                rd_data,
  output logic                            rd_sec,
  output logic                            rd_ded,
  // Program and erase admission
  input  wire logic                       pe_req,
  input  wire logic [2:0]                 pe_bank,
  output logic                            pe_grant,
  output logic                            pe_refuse,
  // Flash array
  output logic                            array_read,
  output logic      [31:0]                array_addr,
  input  wire logic [127:0]               array_data,
  input  wire logic [15:0]                array_check,
  // Bank and pump power controls
  output logic      [NUM_BANKS-1:0]       bank_amp_en,
  output logic      [NUM_BANKS-1:0]       bank_ref_en,
  output logic                            pump_on,
  // Fault signalling
  output logic                            fault_collector_group3,
  output logic                            fault_output_low
);

  typedef enum logic [1:0] {S_IDLE, S_WAKE, S_FETCH} fri_st_type;

  typedef struct packed {
    fri_st_type    st;
    logic          cfg_phase;
    logic [31:0]   addr;
    logic          wide;
    logic [2:0]    bank;
    logic [4:0]    cnt;
    logic [127:0]  line;
    logic [15:0]   line_chk;
    logic [27:0]   tag;
    logic          buf_valid;
    logic          pipe_en;
    logic [1:0]    aws;
    logic [3:0]    dws;
    logic          sm_wen;
    logic [1:0]    d7_aws;
    logic [3:0]    d7_dws;
    logic [15:0]   bank_fb;
    logic [15:0]   bank_idle;
    logic [1:0]    pump_fb;
    logic [15:0]   pump_idle;
    logic [63:0]   cfg_vec;
    logic          ded_flag;
    logic          rd_valid;
    logic [63:0]   rd_data;
    logic          rd_sec;
    logic          rd_ded;
    logic [31:0]   prdata;
    logic          pslverr;
    logic          pe_grant;
    logic          pe_refuse;
  } fri_state_type;

  fri_state_type                  s;
  fri_state_type                  next_s;
  logic [NUM_BANKS-1:0][1:0]      bank_mode;
  logic [1:0]                     pump_mode;
  logic [1:0]                     pump_fb_eff;
  logic                           accept;
  logic                           hit;
  logic                           capture;
  logic                           waking;
  logic [2:0]                     req_bank;
  logic [63:0]                    dec_data;
  logic [7:0]                     dec_chk;
  logic [63:0]                    dec_fixed;
  logic                           dec_sec;
  logic                           dec_ded;
  logic [31:0]                    rd_mux;
  logic                           mapped;

  // OTP region belongs to bank 0, else bank number from address bits
  assign req_bank = (rd_addr[31:28] == OTP_REGION) ? 3'h0 : rd_addr[BANK_LSB+:3];
  assign rd_ready = ce && (s.st == S_IDLE);
  assign accept   = rd_req && rd_ready;
  assign hit      = s.pipe_en && s.buf_valid && (s.tag == rd_addr[31:4]);
  assign capture  = (s.st == S_FETCH) && (s.cnt == 5'h00);
  assign waking   = (s.st == S_WAKE) || (s.st == S_FETCH);

  // Decoder looks at the buffer on a hit, at the array while fetching
  always_comb begin
    if (s.st == S_IDLE) begin
      dec_data = rd_addr[3] ? s.line[127:64] : s.line[63:0];
      dec_chk  = rd_addr[3] ? s.line_chk[15:8] : s.line_chk[7:0];
    end else begin
      dec_data = s.addr[3] ? array_data[127:64] : array_data[63:0];
      dec_chk  = s.addr[3] ? array_check[15:8] : array_check[7:0];
    end
  end

  fri_secded u_secded (
    .data  (dec_data),
    .check (dec_chk),
    .fixed (dec_fixed),
    .sec   (dec_sec),
    .ded   (dec_ded)
  );

  // Pump has no standby, so a standby fallback sleeps it
  assign pump_fb_eff = (s.pump_fb == PWR_STANDBY) ? PWR_SLEEP : s.pump_fb;

  // One sequencer per bank
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    fri_pwr_unit u_bank (
      .core_clk   (core_clk),
      .rst        (rst),
      .ce         (ce),
      .touch      (accept && req_bank == 3'(b)),
      .wake       (waking && s.bank == 3'(b)),
      .fallback   (s.bank_fb[2*b+:2]),
      .idle_limit (s.bank_idle),
      .mode       (bank_mode[b])
    );
    assign bank_amp_en[b] = (bank_mode[b] == PWR_ACTIVE);
    assign bank_ref_en[b] = (bank_mode[b] != PWR_SLEEP);
  end

  fri_pwr_unit u_pump (
    .core_clk   (core_clk),
    .rst        (rst),
    .ce         (ce),
    .touch      (accept),
    .wake       (waking),
    .fallback   (pump_fb_eff),
    .idle_limit (s.pump_idle),
    .mode       (pump_mode)
  );
  assign pump_on = (pump_mode == PWR_ACTIVE);

  // Register read mux and address decode
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      REG_READ_CTRL: rd_mux = {12'h000, s.dws, 6'h00, s.aws, 7'h00, s.pipe_en};
      REG_SM_WEN:    rd_mux = {31'h0, s.sm_wen};
      REG_DBANK_CFG: rd_mux = {12'h000, s.d7_dws, 6'h00, s.d7_aws, 8'h00};
      REG_BANK_PWR:  rd_mux = {s.bank_idle, s.bank_fb};
      REG_PUMP_PWR1: rd_mux = {30'h0, s.pump_fb};
      REG_PUMP_PWR2: rd_mux = {16'h0000, s.pump_idle};
      REG_STATUS:    rd_mux = {10'h000, s.ded_flag, !s.cfg_phase, 2'h0, pump_mode, bank_mode};
      REG_CFG_LO:    rd_mux = s.cfg_vec[31:0];
      REG_CFG_HI:    rd_mux = s.cfg_vec[63:32];
      default: begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  // Next state of registers, read sequencer and responses
  always_comb begin
    next_s           = s;
    next_s.rd_valid  = 1'b0;
    next_s.pe_grant  = 1'b0;
    next_s.pe_refuse = 1'b0;
    // Read data and error are settled in the setup phase
    if (psel && !penable) begin
      next_s.prdata  = rd_mux;
      next_s.pslverr = !mapped;
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        REG_READ_CTRL: begin
          next_s.pipe_en = pwdata[PIPE_BIT];
          next_s.aws     = pwdata[AWS_LSB+:2];
          next_s.dws     = pwdata[DWS_LSB+:4];
        end
        REG_SM_WEN: next_s.sm_wen = pwdata[SMWEN_BIT];
        REG_DBANK_CFG: begin
          if (s.sm_wen) begin
            next_s.d7_aws = pwdata[AWS_LSB+:2];
            next_s.d7_dws = pwdata[DWS_LSB+:4];
          end
        end
        REG_BANK_PWR: begin
          next_s.bank_fb   = pwdata[15:0];
          next_s.bank_idle = pwdata[IDLE_LSB+:16];
        end
        REG_PUMP_PWR1: next_s.pump_fb   = pwdata[1:0];
        REG_PUMP_PWR2: next_s.pump_idle = pwdata[15:0];
        default: ;
      endcase
    end
    // Program and erase only on an active bank
    if (pe_req) begin
      if (bank_mode[pe_bank] == PWR_ACTIVE) next_s.pe_grant = 1'b1;
      else next_s.pe_refuse = 1'b1;
    end
    case (s.st)
      S_IDLE: begin
        if (rd_req) begin
          next_s.addr = rd_addr;
          next_s.wide = rd_wide;
          next_s.bank = req_bank;
          if (hit) begin
            next_s.rd_valid = 1'b1;
            next_s.rd_sec   = dec_sec;
            next_s.rd_ded   = dec_ded;
            next_s.rd_data  = rd_wide ? dec_fixed :
              {32'h0, rd_addr[2] ? dec_fixed[63:32] : dec_fixed[31:0]};
          end else begin
            // Wait count is frozen here, so later writes hit the next access
            next_s.st  = S_WAKE;
            next_s.cnt = (req_bank == DATA_BANK) ?
              {3'h0, s.d7_aws} + {1'h0, s.d7_dws} :
              {3'h0, s.aws} + {1'h0, s.dws};
          end
        end
      end
      S_WAKE: begin
        if (bank_mode[s.bank] == PWR_ACTIVE && pump_mode == PWR_ACTIVE) begin
          next_s.st = S_FETCH;
        end
      end
      S_FETCH: begin
        if (s.cnt != 5'h00) begin
          next_s.cnt = s.cnt - 5'h01;
        end else if (s.cfg_phase) begin
          next_s.cfg_vec   = dec_fixed;
          next_s.ded_flag  = dec_ded;
          next_s.cfg_phase = 1'b0;
          next_s.st        = S_IDLE;
        end else begin
          next_s.line      = array_data;
          next_s.line_chk  = array_check;
          next_s.tag       = s.addr[31:4];
          next_s.buf_valid = s.pipe_en;
          next_s.rd_valid  = 1'b1;
          next_s.rd_sec    = dec_sec;
          next_s.rd_ded    = dec_ded;
          next_s.rd_data   = s.wide ? dec_fixed :
            {32'h0, s.addr[2] ? dec_fixed[63:32] : dec_fixed[31:0]};
          next_s.st        = S_IDLE;
        end
      end
      default: next_s.st = S_IDLE;
    endcase
  end

  // State register; reset starts the vector fetch at once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s           <= '0;
      s.st        <= S_FETCH;
      s.cfg_phase <= 1'b1;
      s.addr      <= OTP_CFG_ADDR;
      s.cnt       <= RST_CNT;
      s.pipe_en   <= RST_PIPE;
      s.aws       <= RST_AWS;
      s.dws       <= RST_DWS;
      s.d7_aws    <= RST_AWS;
      s.d7_dws    <= RST_DWS;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Outputs
  assign pready                 = 1'b1;
  assign prdata                 = s.prdata;
  assign pslverr                = s.pslverr;
  assign rd_valid               = s.rd_valid;
  assign rd_data                = s.rd_data;
  assign rd_sec                 = s.rd_sec;
  assign rd_ded                 = s.rd_ded;
  assign pe_grant               = s.pe_grant;
  assign pe_refuse              = s.pe_refuse;
  assign array_read             = (s.st == S_FETCH);
  assign array_addr             = {s.addr[31:4], 4'h0};
  assign fault_collector_group3 = s.ded_flag;
  assign fault_output_low       = !s.ded_flag;

  // Checks on the read path, power and fault behaviour
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence miss_accept_s;
    accept && !hit;
  endsequence

  sequence fetch_done_s;
    ce && capture && !s.cfg_phase;
  endsequence

  hit_no_wait_a: assert property (accept && hit |=> rd_valid)
    else $error("buffer hit not answered next cycle");
  zero_wait_a: assert property (
    miss_accept_s ##1 (ce && s.st == S_WAKE && s.cnt == 5'h00 && pump_on &&
    bank_mode[s.bank] == PWR_ACTIVE) ##1 ce |=> rd_valid)
    else $error("zero-wait read not answered");
  wait_count_a: assert property (
    ce && s.st == S_FETCH && s.cnt != 5'h00 |=> s.cnt == $past(s.cnt) - 5'h01)
    else $error("wait count did not step down by one");
  fetch_active_a: assert property (
    s.st == S_FETCH |-> bank_mode[s.bank] == PWR_ACTIVE && pump_on)
    else $error("fetch while bank or pump not active");
  fetch_answer_a: assert property (fetch_done_s |=> rd_valid && s.st == S_IDLE)
    else $error("fetch end without answer");
  ded_fault_a: assert property (
    ce && capture && s.cfg_phase && dec_ded |=> !fault_output_low && fault_collector_group3)
    else $error("double error in vector not signalled");
  sec_silent_a: assert property (
    ce && capture && s.cfg_phase && !dec_ded |=> fault_output_low && !s.ded_flag)
    else $error("single error in vector raised a fault");
  dbank_lock_a: assert property (
    psel && penable && pwrite && paddr == REG_DBANK_CFG && !s.sm_wen
    |=> $stable(s.d7_aws) && $stable(s.d7_dws))
    else $error("data bank config written while locked");
  pe_guard_a: assert property (
    ce && pe_req && bank_mode[pe_bank] != PWR_ACTIVE |=> pe_refuse && !pe_grant)
    else $error("program or erase granted on inactive bank");

endmodule : fri_flash_read_if
`default_nettype wire

// File: verification/fri_array_model.sv
// Flash array model: line contents, check bytes and planted bit errors
`timescale 1ns/100ps
`default_nettype none
module fri_array_model
  import fri_pkg::*;
(
  // Fetch side
  input  wire logic         array_read,
  input  wire logic [31:0]  array_addr,
  input  wire logic [1:0]   vec_err,
  // Returned line
  output logic      [127:0] array_data,
  output logic      [15:0]  array_check
);
  logic [127:0] line;
  logic [127:0] flip;

  // Check byte of one half; extended Hamming with overall parity
  function automatic logic [7:0] enc(input logic [63:0] d);
    logic [71:0] cw;
    logic [7:0]  c;
    int          j;
    cw = '0;
    c = '0;
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 7; k++) begin
      for (int p = 1; p < 72; p++) begin
        if (p[k]) c[k] ^= cw[p];
      end
    end
    c[7] = ^{c[6:0], d};
    return c;
  endfunction : enc

  // Check bits always cover clean data, so flips read as stored errors
  always_comb begin
    line = {~array_addr, array_addr ^ 32'h3C3C_3C3C, array_addr ^ 32'h5A5A_5A5A, array_addr};
    flip = '0;
    if (array_addr == OTP_CFG_ADDR && vec_err != 2'h0) flip[3] = 1'b1;
    if (array_addr == OTP_CFG_ADDR && vec_err == 2'h2) flip[9] = 1'b1;
    if (array_addr == SEC_TEST_ADDR) flip[7] = 1'b1;
    if (array_addr == SEC_TEST_ADDR) flip[100] = 1'b1;
    if (array_addr == SEC_TEST_ADDR) flip[65] = 1'b1;
    array_check = {enc(line[127:64]), enc(line[63:0])};
    // Outside a fetch the lines show no stale data
    array_data = array_read ? (line ^ flip) : ~line;
  end

endmodule : fri_array_model
`default_nettype wire

// File: verification/fri_flash_read_if_tb.sv
// Self-checking bench of the flash read interface
`timescale 1ns/100ps
`default_nettype none
module fri_flash_read_if_tb
  import fri_pkg::*;
;
  logic         core_clk, rst, ce, psel, penable, pwrite, pready, pslverr, re;
  logic         rd_req, rd_wide, rd_ready, rd_valid, rd_sec, rd_ded, pe_req;
  logic         pe_grant, pe_refuse, array_read, pump_on;
  logic         fault_collector_group3, fault_output_low;
  logic [7:0]   paddr, bank_amp_en, bank_ref_en;
  logic [31:0]  pwdata, prdata, rd_addr, array_addr, rq;
  logic [63:0]  rd_data;
  logic [127:0] array_data;
  logic [15:0]  array_check;
  logic [2:0]   pe_bank;
  logic [1:0]   verr;
  int           failures, cmp_count, cyc;

  fri_flash_read_if i_fri_flash_read_if (.core_clk, .rst, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rd_req, .rd_addr, .rd_wide, .rd_ready,
    .rd_valid, .rd_data, .rd_sec, .rd_ded, .pe_req, .pe_bank, .pe_grant, .pe_refuse,
    .array_read, .array_addr, .array_data, .array_check, .bank_amp_en, .bank_ref_en,
    .pump_on, .fault_collector_group3, .fault_output_low);
  fri_array_model i_fri_array_model (.array_read, .array_addr, .vec_err(verr),
    .array_data, .array_check);

  // Contents the array model holds for a line
  function automatic logic [127:0] line_of(input logic [31:0] a);
    logic [31:0] b;
    b = {a[31:4], 4'h0};
    return {~b, b ^ 32'h3C3C_3C3C, b ^ 32'h5A5A_5A5A, b};
  endfunction : line_of

  function automatic logic [63:0] exp_of(input logic [31:0] a, input logic w);
    logic [127:0] l;
    l = line_of(a);
    if (w) return a[3] ? l[127:64] : l[63:0];
    return {32'h0, l[32*a[3:2] +: 32]};
  endfunction : exp_of

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // APB transfer; result left in rq and re
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Master read; latency counted in edges from the taking edge
  task automatic rd_chk(input logic [31:0] a, input logic w, input int le);
    int n;
    @(posedge core_clk);
    rd_req <= 1'b1;
    rd_addr <= a;
    rd_wide <= w;
    do @(posedge core_clk); while (rd_ready !== 1'b1);
    rd_req <= 1'b0;
    n = 0;
    // A buffer hit answers in the cycle right after the taking edge
    #1;
    while (rd_valid !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("latency", 64'(le), 64'(n));
    if (a[31:28] != OTP_REGION) chk("rd_data", exp_of(a, w), rd_data);
  endtask : rd_chk

  task automatic pe(input logic [2:0] b, input logic [1:0] e);
    @(posedge core_clk);
    pe_req <= 1'b1;
    pe_bank <= b;
    @(posedge core_clk);
    pe_req <= 1'b0;
    #1;
    chk("pe_answer", 64'(e), {62'h0, pe_grant, pe_refuse});
  endtask : pe

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    logic [31:0]  q, a;
    logic [127:0] l;
    int           n;
    int           aw[3] = '{0, 1, 3};
    int           dw[3] = '{0, 3, 15};
    {rst, ce, psel, penable, pwrite, rd_req, rd_wide, pe_req} = 8'hC0;
    {paddr, pwdata, rd_addr, pe_bank, verr} = '0;
    a = $urandom(22172);
    l = line_of(OTP_CFG_ADDR);
    // Double, then single, then no error in the reset vector
    for (int e = 2; e >= 0; e--) begin
      verr <= 2'(e);
      rst <= 1'b1;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      n = 0;
      do begin @(posedge core_clk); n++; end while (rd_ready !== 1'b1 && n < 50);
      chk("power", 64'h1_FFFF, {47'h0, bank_amp_en, bank_ref_en, pump_on});
      apb(1'b0, REG_STATUS, 32'h0);
      chk("fault", {61'h0, e == 2, e == 2, e != 2},
          {61'h0, rq[21], fault_collector_group3, fault_output_low});
      apb(1'b0, REG_CFG_LO, 32'h0);
      q = rq;
      apb(1'b0, REG_CFG_HI, 32'h0);
      if (e != 2) chk("vector", l[63:0], {rq, q});
    end
    apb(1'b0, REG_READ_CTRL, 32'h0);
    chk("read_ctrl", 64'h0003_0100, {32'h0, rq});
    apb(1'b0, 8'h24, 32'h0);
    chk("slverr", 64'h1, {63'h0, re});
    // Locked data-bank register, then unlocked
    apb(1'b1, REG_DBANK_CFG, 32'h0);
    apb(1'b0, REG_DBANK_CFG, 32'h0);
    chk("dbank_cfg", 64'h0003_0100, {32'h0, rq});
    apb(1'b1, REG_SM_WEN, 32'h1);
    apb(1'b1, REG_DBANK_CFG, 32'h0002_0000);
    apb(1'b0, REG_DBANK_CFG, 32'h0);
    chk("dbank_cfg", 64'h0002_0000, {32'h0, rq});
    rd_chk({8'h00, DATA_BANK, 21'h0_0100}, 1'b1, 4);
    // Wait state table, random addresses and widths
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, REG_READ_CTRL, (dw[i] << 16) | (aw[i] << 8));
      repeat (2) begin
        a = {8'h00, 3'($urandom_range(6)), 19'($urandom), 2'h0};
        rd_chk(a, 1'($urandom), 2 + aw[i] + dw[i]);
      end
    end
    // Pipeline: miss, then hits on the same line
    apb(1'b1, REG_READ_CTRL, 32'h0003_0101);
    rd_chk(a, 1'b1, 6);
    rd_chk(a ^ 32'h8, 1'b1, 0);
    rd_chk(a ^ 32'h4, 1'b0, 0);
    apb(1'b1, REG_READ_CTRL, 32'h0003_0100);
    for (int w = 0; w < 2; w++) begin
      rd_chk(SEC_TEST_ADDR, 1'(w), 6);
      chk("ecc_flags", 64'h2, {62'h0, rd_sec, rd_ded});
      rd_chk(DED_TEST_ADDR, 1'(w), 6);
      chk("ecc_flags", 64'h1, {62'h0, rd_sec, rd_ded});
    end
    // Settings changed while a fetch runs
    fork
      rd_chk(a ^ 32'h10, 1'b1, 6);
      apb(1'b1, REG_READ_CTRL, 32'h0);
    join
    rd_chk(a ^ 32'h20, 1'b0, 2);
    // Enable low for three edges freezes a zero-wait miss by three cycles
    fork
      rd_chk(a ^ 32'h30, 1'b1, 5);
      begin
        repeat (2) @(posedge core_clk);
        ce <= 1'b0;
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
      end
    join
    // Idle fallback: bank 0 sleep, bank 1 standby, pump sleep
    apb(1'b1, REG_BANK_PWR, 32'h000A_0006);
    apb(1'b1, REG_PUMP_PWR1, 32'h2);
    apb(1'b1, REG_PUMP_PWR2, 32'hA);
    repeat (30) @(posedge core_clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 64'h0012_0006, {32'h0, rq});
    chk("power", {47'h0, 8'hFC, 8'hFE, 1'b0}, {47'h0, bank_amp_en, bank_ref_en, pump_on});
    pe(3'h0, 2'h1);
    pe(3'h2, 2'h2);
    rd_chk({8'h00, 3'h0, 21'h0_0400}, 1'b1, 2 + 32'(WAKE_CYCLES));
    chk("woken", 64'h3, {62'h0, bank_amp_en[0], pump_on});
    close_out();
  end

endmodule : fri_flash_read_if_tb
`default_nettype wire
